/* logic/tmr_consts.vh */
// tmr_consts.vh: register offsets, field positions, reset values and prescale counts
// assumes: included by the timer design files; definitions only
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// mask index is not word aligned, so its byte address is four times the index
`define TMR_IDX_MASK 12'h06e
`define TMR_OFF_MASK 12'h1b8
`define TMR_OFF_CTRL 12'h070
`define TMR_OFF_COUNT 12'h074
`define TMR_OFF_COMPARE 12'h078
`define TMR_OFF_FLAGS 12'h07c
`define TMR_BIT_FORCE 7
`define TMR_BIT_MODE_HI 6
`define TMR_BIT_MODE_LO 3
`define TMR_BIT_COM_HI 5
`define TMR_BIT_COM_LO 4
`define TMR_BIT_CS_HI 2
`define TMR_BIT_CMP 1
`define TMR_BIT_OVF 0
`define TMR_RST_BYTE 8'h00
`define TMR_MAX 8'hff
`define TMR_BOTTOM 8'h00
`define TMR_MODE_NORMAL 2'h0
`define TMR_MODE_PCPWM 2'h1
`define TMR_MODE_CTC 2'h2
`define TMR_MODE_FPWM 2'h3
`define TMR_DIV_8 10'h007
`define TMR_DIV_64 10'h03f
`define TMR_DIV_256 10'h0ff
`define TMR_DIV_1024 10'h3ff
`endif

/* logic/tmr_prescale.v */
// tmr_prescale.v: free-running prescaler and clock-select enable generator
// assumes: one system clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"
module tmr_prescale (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    input wire clk_en,
    // selection and external edges
    input wire [2:0] clock_sel,
    input wire ext_fall,
    input wire ext_rise,
    // timer clock enable
    output reg tick
);
    reg [9:0] presc;

    // free-running divider
    always @(posedge clk_sys) begin
        if (!nrst) begin
            presc <= 10'h000;
        end else if (clk_en) begin
            presc <= presc + 10'h001;
        end
    end

    // enable selection
    always @* begin
        case (clock_sel)
            3'h1: tick = clk_en;
            3'h2: tick = clk_en && ((presc & `TMR_DIV_8) == `TMR_DIV_8);
            3'h3: tick = clk_en && ((presc & `TMR_DIV_64) == `TMR_DIV_64);
            3'h4: tick = clk_en && ((presc & `TMR_DIV_256) == `TMR_DIV_256);
            3'h5: tick = clk_en && (presc == `TMR_DIV_1024);
            3'h6: tick = clk_en && ext_fall;
            3'h7: tick = clk_en && ext_rise;
            default: tick = 1'b0; // stopped
        endcase
    end
endmodule // tmr_prescale
`default_nettype wire

/* logic/tmr_edge.v */
// tmr_edge.v: two-stage synchroniser with edge detector for the count pin
// assumes: pin input read straight from the pad regardless of direction
`timescale 1ns/1ps
`default_nettype none
module tmr_edge (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    input wire clk_en,
    // pin
    input wire pin_in,
    // edge pulses
    output wire rise,
    output wire fall
);
    reg s1;
    reg s2;
    reg s3;

    // synchroniser and history
    always @(posedge clk_sys) begin
        if (!nrst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (clk_en) begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // one-cycle edge pulses
    assign rise = s2 & ~s3;
    assign fall = ~s2 & s3;
endmodule // tmr_edge
`default_nettype wire

/* logic/tmr_timer8.v */
// tmr_timer8.v: 8-bit timer with one compare unit, four waveform modes, apb registers
// assumes: apb master on clk_sys; port logic uses pin_out_en and compare_out_pin
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"
module tmr_timer8 (
    // clock, reset, enable
    input wire clk_sys,
    input wire nrst,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // cpu side
    input wire global_irq_en,
    input wire cmp_vector_ack,
    input wire ovf_vector_ack,
    output reg cmp_irq,
    output reg ovf_irq,
    // pins
    input wire ext_count_pin,
    input wire pin_dir,
    input wire port_data,
    output reg compare_out_pin,
    output reg pin_out_en
);
    reg [7:0] ctrl;
    reg [7:0] count_reg;
    reg [7:0] compare_value_reg;
    reg [7:0] cmp_buf;
    reg [1:0] irq_mask_reg;
    reg compare_flag;
    reg overflow_flag;
    reg wave;
    reg count_down;
    reg block_match;
    wire ext_rise;
    wire ext_fall;
    wire tick;

    wire [1:0] waveform_mode_sel = {ctrl[`TMR_BIT_MODE_HI], ctrl[`TMR_BIT_MODE_LO]};
    wire [1:0] compare_out_mode = ctrl[`TMR_BIT_COM_HI:`TMR_BIT_COM_LO];
    wire [2:0] clock_sel = ctrl[`TMR_BIT_CS_HI:0];
    wire is_pc = (waveform_mode_sel == `TMR_MODE_PCPWM);
    wire is_fast = (waveform_mode_sel == `TMR_MODE_FPWM);
    wire is_ctc = (waveform_mode_sel == `TMR_MODE_CTC);
    wire is_pwm = is_pc | is_fast;

    // apb decode
    wire acc = psel & penable & ~pready;
    wire wr = acc & pwrite;
    wire hit_mask = (paddr == `TMR_OFF_MASK);
    wire hit_ctrl = (paddr == `TMR_OFF_CTRL);
    wire hit_count = (paddr == `TMR_OFF_COUNT);
    wire hit_cmp = (paddr == `TMR_OFF_COMPARE);
    wire hit_flags = (paddr == `TMR_OFF_FLAGS);
    wire hit_any = hit_mask | hit_ctrl | hit_count | hit_cmp | hit_flags;
    wire wr_count = wr & hit_count;
    wire wr_ctrl = wr & hit_ctrl;
    wire force_cmp = wr_ctrl & pwdata[`TMR_BIT_FORCE] & ~(pwdata[`TMR_BIT_MODE_LO]);

    // counter events
    wire match = (count_reg == cmp_buf);
    wire top_special = compare_out_mode[1] & (cmp_buf == `TMR_MAX);
    wire at_max = (count_reg == `TMR_MAX);
    wire at_bottom = (count_reg == `TMR_BOTTOM);
    wire match_ev = tick & match & ~block_match;
    wire ovf_ev = tick & (is_pc ? (at_bottom & count_down) : at_max);

    tmr_edge u_edge (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin_in(ext_count_pin),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    tmr_prescale u_presc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clk_en(clk_en),
        .clock_sel(clock_sel),
        .ext_fall(ext_fall),
        .ext_rise(ext_rise),
        .tick(tick)
    );

    // next count value by mode
    reg [7:0] next_count;
    reg next_down;
    always @* begin
        next_count = count_reg + 8'h01;
        next_down = count_down;
        case (waveform_mode_sel)
            `TMR_MODE_CTC: begin
                if (match) next_count = `TMR_BOTTOM;
            end
            `TMR_MODE_PCPWM: begin
                if (!count_down && at_max) begin
                    next_count = count_reg - 8'h01; // max stands for one timer clock only
                    next_down = 1'b1;
                end else if (count_down && at_bottom) begin
                    next_count = count_reg + 8'h01;
                    next_down = 1'b0;
                end else if (count_down) begin
                    next_count = count_reg - 8'h01;
                end
            end
            default: begin
                next_count = count_reg + 8'h01; // wraps max to zero
                next_down = 1'b0;
            end
        endcase
    end

    // counter, direction, match blocking
    always @(posedge clk_sys) begin
        if (!nrst) begin
            count_reg <= `TMR_RST_BYTE;
            count_down <= 1'b0;
            block_match <= 1'b0;
        end else if (clk_en) begin
            if (wr_count) begin
                count_reg <= pwdata[7:0];
                block_match <= 1'b1;
            end else if (tick) begin
                count_reg <= next_count;
                count_down <= next_down;
                block_match <= 1'b0;
            end
            if (!is_pc) count_down <= 1'b0;
        end
    end

    // compare value and its active buffer
    always @(posedge clk_sys) begin
        if (!nrst) begin
            compare_value_reg <= `TMR_RST_BYTE;
            cmp_buf <= `TMR_RST_BYTE;
        end else if (clk_en) begin
            if (wr & hit_cmp) compare_value_reg <= pwdata[7:0];
            if (!is_pwm) begin
                cmp_buf <= (wr & hit_cmp) ? pwdata[7:0] : compare_value_reg;
            end else if (tick && is_fast && at_max) begin
                cmp_buf <= compare_value_reg; // loads as count goes to bottom
            end else if (tick && is_pc && at_max && !count_down) begin
                cmp_buf <= compare_value_reg; // loads at top
            end
        end
    end

    // control and mask registers
    always @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl <= `TMR_RST_BYTE;
            irq_mask_reg <= 2'h0;
        end else if (clk_en) begin
            if (wr_ctrl) ctrl <= {1'b0, pwdata[6:0]};
            if (wr & hit_mask) irq_mask_reg <= pwdata[1:0];
        end
    end

    // flags: hardware set wins over clear
    always @(posedge clk_sys) begin
        if (!nrst) begin
            compare_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (clk_en) begin
            if (match_ev) compare_flag <= 1'b1;
            else if ((wr & hit_flags & pwdata[`TMR_BIT_CMP]) | cmp_vector_ack) compare_flag <= 1'b0;
            if (ovf_ev) overflow_flag <= 1'b1;
            else if ((wr & hit_flags & pwdata[`TMR_BIT_OVF]) | ovf_vector_ack) overflow_flag <= 1'b0;
        end
    end

    // pwm events; a compare value at top never matches
    wire pwm_match = match & ~block_match & ~top_special;
    wire pc_top = top_special & at_max & ~count_down; // top case acts on the way up
    // the output mode written with the force strobe decides its action
    wire [1:0] force_mode = pwdata[`TMR_BIT_COM_HI:`TMR_BIT_COM_LO];
    // output mode seen by the pin from the edge the control write lands
    wire [1:0] pin_mode = wr_ctrl ? force_mode : compare_out_mode;

    // waveform generator: one action per edge, force first
    reg next_wave;
    reg [1:0] act_mode;
    reg act;
    always @* begin
        next_wave = wave;
        act_mode = compare_out_mode;
        act = 1'b0;
        if (force_cmp) begin
            act_mode = force_mode;
            act = 1'b1;
        end else if (!is_pwm) begin
            act = match_ev;
        end
        if (act) begin
            case (act_mode)
                2'h1: next_wave = ~wave;
                2'h2: next_wave = 1'b0;
                2'h3: next_wave = 1'b1;
                default: next_wave = wave;
            endcase
        end else if (is_pwm && compare_out_mode[1] && tick) begin
            if (is_fast) begin
                if (at_max) begin
                    next_wave = ~compare_out_mode[0]; // action as count goes to bottom
                end else if (pwm_match) begin
                    next_wave = compare_out_mode[0];
                end
            end else begin
                if (pc_top) begin
                    next_wave = ~compare_out_mode[0]; // same level as a down-count match
                end else if (pwm_match) begin
                    next_wave = count_down ? ~compare_out_mode[0] : compare_out_mode[0];
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            wave <= 1'b0;
        end else if (clk_en) begin
            wave <= next_wave;
        end
    end

    // pin mux and interrupt requests
    always @(posedge clk_sys) begin
        if (!nrst) begin
            compare_out_pin <= 1'b0;
            pin_out_en <= 1'b0;
            cmp_irq <= 1'b0;
            ovf_irq <= 1'b0;
        end else if (clk_en) begin
            compare_out_pin <= (pin_mode != 2'h0) ? next_wave : port_data;
            pin_out_en <= pin_dir;
            cmp_irq <= (compare_flag | match_ev) & irq_mask_reg[1] & global_irq_en;
            ovf_irq <= (overflow_flag | ovf_ev) & irq_mask_reg[0] & global_irq_en;
        end
    end

    // read data of the addressed register, zero on writes and unmapped reads
    wire rd_acc = acc & ~pwrite;
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        if (rd_acc & hit_mask) next_prdata = {30'h0, irq_mask_reg};
        if (rd_acc & hit_ctrl) next_prdata = {24'h0, 1'b0, ctrl[6:0]};
        if (rd_acc & hit_count) next_prdata = {24'h0, count_reg};
        if (rd_acc & hit_cmp) next_prdata = {24'h0, compare_value_reg};
        if (rd_acc & hit_flags) next_prdata = {30'h0, compare_flag, overflow_flag};
    end

    // apb answer: one wait state, unmapped gives slverr
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= acc;
            pslverr <= acc & ~hit_any;
            prdata <= next_prdata;
        end
    end
endmodule // tmr_timer8
`default_nettype wire

/* bench/tmr_timer8_monitor.sv */
// tmr_timer8_monitor.sv: port-level checker for tmr_timer8
// assumes: bound into the design; one clock domain, clk_en low only while the bus is idle
`timescale 1ns/1ps
`default_nettype none
module tmr_timer8_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // cpu side and pins
    input wire logic global_irq_en,
    input wire logic cmp_irq,
    input wire logic ovf_irq,
    input wire logic pin_dir,
    input wire logic pin_out_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // apb answer: one wait state, one-cycle pulse, caused by a full request
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_cause; $rose(pready) |-> $past(psel && penable) && $past(psel, 2); endproperty
    a_cause: assert property (p_cause) else $error("pready uncaused");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits");
    // pin driver and interrupt gating
    property p_dir; 1'b1 |=> pin_out_en == $past(pin_dir); endproperty
    a_dir: assert property (p_dir) else $error("driver enable");
    property p_cgie; !global_irq_en |=> !cmp_irq; endproperty
    a_cgie: assert property (p_cgie) else $error("cmp irq ungated");
    property p_ogie; !global_irq_en |=> !ovf_irq; endproperty
    a_ogie: assert property (p_ogie) else $error("ovf irq ungated");
    // main scenarios reached
    c_err: cover property (pready && pslverr);
    c_cmp: cover property ($rose(cmp_irq));
    c_ovf: cover property ($rose(ovf_irq));
endmodule // tmr_timer8_monitor
bind tmr_timer8 tmr_timer8_monitor u_mon (.clk_sys, .nrst, .psel, .penable, .prdata, .pready, .pslverr,
    .global_irq_en, .cmp_irq, .ovf_irq, .pin_dir, .pin_out_en);
`default_nettype wire

/* bench/tb_tmr_timer8.sv */
// tb_tmr_timer8.sv: self-checking bench for the 8-bit timer, seeded random values
// assumes: header on the include path; clk_en dropped once while the bus is idle
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.vh"
module tb_tmr_timer8;
    logic clk_sys = 0, nrst = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdq;
    logic global_irq_en = 0, cmp_vector_ack = 0, ovf_vector_ack = 0;
    logic ext_count_pin = 0, pin_dir = 0, port_data = 0, rerr;
    wire [31:0] prdata;
    wire pready, pslverr, cmp_irq, ovf_irq, compare_out_pin, pin_out_en;
    int n_checks = 0, n_mismatch = 0, n, c, h;
    int dv [6] = '{0, 1, 8, 64, 256, 1024};
    localparam logic [11:0] r_mask = `TMR_OFF_MASK, r_ctrl = `TMR_OFF_CTRL;
    localparam logic [11:0] r_cnt = `TMR_OFF_COUNT, r_cmp = `TMR_OFF_COMPARE, r_flg = `TMR_OFF_FLAGS;

    tmr_timer8 u_dut (.clk_sys, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_irq_en, .cmp_vector_ack, .ovf_vector_ack, .cmp_irq, .ovf_irq,
        .ext_count_pin, .pin_dir, .port_data, .compare_out_pin, .pin_out_en);

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic tk(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one apb transfer: setup, access held until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tk(1);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            tk(1);
            if (pready === 1'b1) break;
        end
        rdq = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        if (i < 20) tk(1);
        else begin
            chk("pready", 32'h0, 32'h1);
            results();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // control word: force 7, mode 6 and 3, output mode 5:4, clock select 2:0
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] o, input logic [2:0] s);
        return {24'h0, 1'b0, m[1], o, m[0], s};
    endfunction
    // high cycles per period: fast pwm for k<3, phase-correct after
    function automatic int pwm_hi(input int k, input int v);
        int x;
        x = (k < 3) ? v + 1 : 2 * v;
        if (k % 3 == 1) x = ((k < 3) ? 256 : 510) - x;
        return x;
    endfunction

    // main sequence
    initial begin
        void'($urandom(46363));
        tk(10);
        nrst <= 1;
        tk(1);
        rd(r_mask);
        chk("mask reset", rdq, 32'h0);
        wr(r_mask, 32'hff);
        rd(r_mask);
        chk("mask bits", rdq, 32'h3);
        rd(12'h080);
        chk("unmapped", {rdq[30:0], rerr}, 32'h1);
        n = $urandom % 256;
        wr(r_cnt, 32'(n));
        rd(r_cnt);
        chk("count rw", rdq, 32'(n));
        $display("test registers done");
        for (int s = 0; s < 6; s++) begin
            wr(r_cnt, 32'h0);
            wr(r_ctrl, ctl(2'd0, 2'd0, s[2:0]));
            tk(4 * dv[s]);
            wr(r_ctrl, 32'h0);
            rd(r_cnt);
            chk("prescale", 32'((s == 0) ? (rdq == 0) : (rdq >= 4 && rdq <= 10)), 32'h1);
        end
        $display("test prescale done");
        pin_dir <= 1;
        for (int s = 6; s < 8; s++) begin
            n = 1 + $urandom % 8;
            ext_count_pin <= 1;
            wr(r_cnt, 32'h0);
            wr(r_ctrl, ctl(2'd0, 2'd0, s[2:0]));
            repeat (n) begin
                ext_count_pin <= 0;
                tk(4);
                ext_count_pin <= 1;
                tk(4);
            end
            ext_count_pin <= 0;
            tk(6);
            rd(r_cnt);
            chk("pin edges", rdq, 32'((s == 6) ? n + 1 : n));
        end
        $display("test count pin done");
        c = 8 + $urandom % 40;
        wr(r_ctrl, 32'h0);
        wr(r_cmp, 32'(c));
        wr(r_cnt, 32'h0);
        wr(r_flg, 32'h3);
        wr(r_ctrl, ctl(2'd2, 2'd1, 3'd1));
        for (int k = 0; k < 3; k++) begin
            h = 0;
            n = 32'(compare_out_pin);
            while (compare_out_pin === n[0] && h < 300) begin
                tk(1);
                h++;
            end
        end
        chk("toggle period", 32'(h), 32'(c + 1));
        wr(r_ctrl, 32'h0);
        rd(r_flg);
        chk("ctc flags", rdq, 32'h2);
        wr(r_flg, 32'h3);
        rd(r_flg);
        chk("flags w1c", rdq, 32'h0);
        $display("test clear on match done");
        port_data <= 1'($urandom);
        pin_dir <= 1'($urandom);
        for (int k = 0; k < 4; k++) begin
            wr(r_ctrl, 32'h80 | ctl(2'd0, 2'(3 - k), 3'd0));
            tk(2);
            chk("force", 32'(compare_out_pin), 32'((k == 3) ? port_data : k != 1));
        end
        rd(r_ctrl);
        chk("force reads 0", rdq, 32'h0);
        rd(r_flg);
        chk("force no flag", rdq, 32'h0);
        for (int k = 0; k < 6; k++) begin
            c = (k % 3 == 2) ? 255 : 1 + $urandom % 254;
            wr(r_ctrl, 32'h0);
            wr(r_cmp, 32'(c));
            wr(r_flg, 32'h3);
            wr(r_ctrl, ctl((k < 3) ? 2'd3 : 2'd1, (k % 3 == 1) ? 2'd3 : 2'd2, 3'd1));
            tk(600);
            h = 0;
            repeat ((k < 3) ? 256 : 510) begin
                tk(1);
                h += 32'(compare_out_pin === 1'b1);
            end
            chk("pwm high", 32'(h), 32'(pwm_hi(k, c)));
            rd(r_flg);
            chk("ovf flag", rdq & 32'h1, 32'h1);
        end
        $display("test pwm done");
        wr(r_ctrl, 32'h0);
        wr(r_cmp, 32'h10);
        wr(r_cnt, 32'h0);
        wr(r_ctrl, ctl(2'd0, 2'd0, 3'd1));
        tk(300);
        wr(r_ctrl, 32'h0);
        wr(r_mask, 32'h3);
        global_irq_en <= 1;
        tk(3);
        chk("irq both", 32'({cmp_irq, ovf_irq}), 32'h3);
        wr(r_mask, 32'h1);
        tk(2);
        chk("irq masked", 32'({cmp_irq, ovf_irq}), 32'h1);
        global_irq_en <= 0;
        tk(3);
        chk("irq off", 32'({cmp_irq, ovf_irq}), 32'h0);
        wr(r_mask, 32'h3);
        global_irq_en <= 1;
        ovf_vector_ack <= 1;
        tk(1);
        ovf_vector_ack <= 0;
        tk(3);
        chk("ovf ack", 32'({cmp_irq, ovf_irq}), 32'h2);
        cmp_vector_ack <= 1;
        tk(1);
        cmp_vector_ack <= 0;
        rd(r_flg);
        chk("cmp ack", rdq, 32'h0);
        wr(r_cmp, 32'h20);
        wr(r_cnt, 32'h80);
        wr(r_ctrl, ctl(2'd0, 2'd0, 3'd1));
        wr(r_cnt, 32'h20);
        wr(r_ctrl, 32'h0);
        rd(r_flg);
        chk("write blocks match", rdq, 32'h0);
        // clock enable low freezes the counter: two ticks before, two after
        wr(r_cnt, 32'h40);
        wr(r_ctrl, ctl(2'd0, 2'd0, 3'd1));
        clk_en <= 0;
        tk(20);
        clk_en <= 1;
        wr(r_ctrl, 32'h0);
        rd(r_cnt);
        chk("enable freeze", rdq, 32'h44);
        $display("test interrupts done");
        results();
    end
endmodule // tb_tmr_timer8
`default_nettype wire
